// ==== rtl/gpio_cfg_pkg.sv ====
// constants for the gpio port configuration sub-registers
package gpio_cfg_pkg;

    localparam int PIN_COUNT = 8;
    localparam int ALT_COUNT = 4;

    typedef enum logic [1:0] {PORT_A, PORT_B, PORT_C, PORT_D} port_t;

    // sub-register index values held in the address register
    localparam logic [7:0] IDX_NONE = 8'h00;
    localparam logic [7:0] IDX_DIR = 8'h01;
    localparam logic [7:0] IDX_AF = 8'h02;
    localparam logic [7:0] IDX_OD = 8'h03;
    localparam logic [7:0] IDX_HD = 8'h04;
    localparam logic [7:0] IDX_WAKE = 8'h05;
    localparam logic [7:0] IDX_PU = 8'h06;
    localparam logic [7:0] IDX_AS1 = 8'h07;
    localparam logic [7:0] IDX_AS2 = 8'h08;
    localparam int IDX_FIRST = 1;
    localparam int IDX_LAST = 8;

    // register select on the port access bus
    localparam logic SEL_ADDR = 1'b0;
    localparam logic SEL_CTL = 1'b1;

    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_AF_D = 8'h01;
    localparam logic [7:0] RST_AF_SMALL_A = 8'h04;
    localparam logic [7:0] RST_AS_SMALL_A = 8'h04;

endpackage : gpio_cfg_pkg

// ==== rtl/gpio_cfg_if.sv ====
// configuration bits passed from the register file to the pin logic
`timescale 1ns/1ps
interface gpio_cfg_if;
    logic [7:0] dir;
    logic [7:0] af;
    logic [7:0] od;
    logic [7:0] hd;
    logic [7:0] wake;
    logic [7:0] pu;
    logic [7:0] as1;
    logic [7:0] as2;

    modport regs (output dir, af, od, hd, wake, pu, as1, as2);
    modport pins (input dir, af, od, hd, wake, pu, as1, as2);
endinterface : gpio_cfg_if

// ==== rtl/gpio_pin_drive.sv ====
// per-pin driver control, pad settings and wake detection
`timescale 1ns/1ps
module gpio_pin_drive (
    input wire logic clk_i,
    input wire logic rstn_i,
    gpio_cfg_if.pins cfg,
    input wire logic [7:0] out_data_i,
    input wire logic [31:0] alt_out_i,
    input wire logic [31:0] alt_oe_i,
    input wire logic [7:0] pin_i,
    input wire logic stop_mode_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_o,
    output logic [7:0] pullup_o,
    output logic [7:0] high_drive_o,
    output logic [15:0] alt_sel_o,
    output logic [7:0] pin_in_o,
    output logic wake_o
);

    // picks the bit of pin p from the alternate function sel
    function automatic logic alt_pick(input logic [31:0] vec, input logic [1:0] sel,
                                      input int p);
        alt_pick = vec[{27'h000_0000, sel, 3'h0} + p];
    endfunction : alt_pick

    logic [7:0] drv_data_w;
    logic [7:0] drv_en_w;
    logic [7:0] oe_w;
    logic [15:0] sel_w;
    logic [7:0] pin_prev_q;
    logic wake_w;

    ////////////////////////////////////////////////////////////////////////////
    // drive selection
    for (genvar p = 0; p < gpio_cfg_pkg::PIN_COUNT; p++)
    begin : g_pin
        assign sel_w[2*p+1:2*p] = {cfg.as2[p], cfg.as1[p]};
        assign drv_data_w[p] = cfg.af[p] ? alt_pick(alt_out_i, sel_w[2*p+1:2*p], p)
                                         : out_data_i[p];
        assign drv_en_w[p] = cfg.af[p] ? alt_pick(alt_oe_i, sel_w[2*p+1:2*p], p)
                                       : ~cfg.dir[p];
    end

    // open drain cuts the high side in both modes
    assign oe_w = drv_en_w & ~(cfg.od & drv_data_w);
    assign wake_w = stop_mode_i & (|((pin_i ^ pin_prev_q) & cfg.wake));

    ////////////////////////////////////////////////////////////////////////////
    // output registers
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pin_o <= '0;
            pin_oe_o <= '0;
            pullup_o <= '0;
            high_drive_o <= '0;
            alt_sel_o <= '0;
            pin_in_o <= '0;
            pin_prev_q <= '0;
            wake_o <= 1'b0;
        end
        else
        begin
            pin_o <= drv_data_w;
            pin_oe_o <= oe_w;
            pullup_o <= cfg.pu;
            high_drive_o <= cfg.hd;
            alt_sel_o <= sel_w;
            pin_in_o <= pin_i;
            pin_prev_q <= pin_i;
            wake_o <= wake_w;
        end
    end

endmodule : gpio_pin_drive

// ==== rtl/gpio_port_cfg.sv ====
// gpio port configuration sub-registers behind the address and control registers
`timescale 1ns/1ps
module gpio_port_cfg #(
    parameter gpio_cfg_pkg::port_t PORT_ID = gpio_cfg_pkg::PORT_A,
    parameter bit SMALL_PACKAGE = 1'b0
) (
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic REG_SEL_I,
    input wire logic WR_EN_I,
    input wire logic RD_EN_I,
    input wire logic [7:0] WDATA_I,
    output logic [7:0] RDATA_O,
    input wire logic [7:0] OUT_DATA_I,
    input wire logic [31:0] ALT_OUT_I,
    input wire logic [31:0] ALT_OE_I,
    input wire logic [7:0] PIN_I,
    input wire logic STOP_MODE_I,
    output logic [7:0] PIN_O,
    output logic [7:0] PIN_OE_O,
    output logic [7:0] PULLUP_O,
    output logic [7:0] HIGH_DRIVE_O,
    output logic [15:0] ALT_SEL_O,
    output logic [7:0] PIN_IN_O,
    output logic WAKE_O
);

    // reset value of each sub-register for this port
    function automatic logic [7:0] reset_value(input int idx);
        logic small_a;
        small_a = SMALL_PACKAGE && (PORT_ID == gpio_cfg_pkg::PORT_A);
        reset_value = gpio_cfg_pkg::RST_ZERO;
        if (idx == int'(gpio_cfg_pkg::IDX_DIR))
            reset_value = gpio_cfg_pkg::RST_DIR;
        else if (idx == int'(gpio_cfg_pkg::IDX_AF))
        begin
            if (small_a)
                reset_value = gpio_cfg_pkg::RST_AF_SMALL_A;
            else if (PORT_ID == gpio_cfg_pkg::PORT_D)
                reset_value = gpio_cfg_pkg::RST_AF_D;
        end
        else if (idx == int'(gpio_cfg_pkg::IDX_AS1) || idx == int'(gpio_cfg_pkg::IDX_AS2))
        begin
            if (small_a)
                reset_value = gpio_cfg_pkg::RST_AS_SMALL_A;
        end
    endfunction : reset_value

    // true for an index that names a sub-register
    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx >= gpio_cfg_pkg::IDX_DIR) && (idx <= gpio_cfg_pkg::IDX_AS2);
    endfunction : is_mapped

    logic [7:0] index_q;
    logic [7:0] sub_q [gpio_cfg_pkg::IDX_FIRST:gpio_cfg_pkg::IDX_LAST];
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic addr_wr_w;
    logic ctl_wr_w;
    logic mapped_w;
    logic [7:0] ctl_read_w;

    gpio_cfg_if cfg ();

    ////////////////////////////////////////////////////////////////////////////
    // access decode
    assign mapped_w = is_mapped(index_q);
    assign addr_wr_w = WR_EN_I && (REG_SEL_I == gpio_cfg_pkg::SEL_ADDR);
    assign ctl_wr_w = WR_EN_I && (REG_SEL_I == gpio_cfg_pkg::SEL_CTL) && mapped_w;
    assign ctl_read_w = mapped_w ? sub_q[index_q[3:0]] : gpio_cfg_pkg::RST_ZERO;

    always_comb
    begin
        rdata_d = rdata_q;
        if (RD_EN_I && REG_SEL_I == gpio_cfg_pkg::SEL_ADDR)
            rdata_d = index_q;
        else if (RD_EN_I && REG_SEL_I == gpio_cfg_pkg::SEL_CTL)
            rdata_d = ctl_read_w;
    end

    ////////////////////////////////////////////////////////////////////////////
    // address register and read data
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            index_q <= gpio_cfg_pkg::IDX_NONE;
            rdata_q <= gpio_cfg_pkg::RST_ZERO;
        end
        else
        begin
            if (addr_wr_w)
                index_q <= WDATA_I;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sub-register array
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            for (int k = gpio_cfg_pkg::IDX_FIRST; k <= gpio_cfg_pkg::IDX_LAST; k++)
                sub_q[k] <= reset_value(k);
        end
        else
        begin
            for (int k = gpio_cfg_pkg::IDX_FIRST; k <= gpio_cfg_pkg::IDX_LAST; k++)
            begin
                if (ctl_wr_w && index_q == 8'(k))
                    sub_q[k] <= WDATA_I;
            end
        end
    end

    assign RDATA_O = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // configuration to pin logic
    assign cfg.dir = sub_q[gpio_cfg_pkg::IDX_DIR];
    assign cfg.af = sub_q[gpio_cfg_pkg::IDX_AF];
    assign cfg.od = sub_q[gpio_cfg_pkg::IDX_OD];
    assign cfg.hd = sub_q[gpio_cfg_pkg::IDX_HD];
    assign cfg.wake = sub_q[gpio_cfg_pkg::IDX_WAKE];
    assign cfg.pu = sub_q[gpio_cfg_pkg::IDX_PU];
    assign cfg.as1 = sub_q[gpio_cfg_pkg::IDX_AS1];
    assign cfg.as2 = sub_q[gpio_cfg_pkg::IDX_AS2];

    gpio_pin_drive u_pins (
        .clk_i(CLOCK_I),
        .rstn_i(RSTN_I),
        .cfg(cfg.pins),
        .out_data_i(OUT_DATA_I),
        .alt_out_i(ALT_OUT_I),
        .alt_oe_i(ALT_OE_I),
        .pin_i(PIN_I),
        .stop_mode_i(STOP_MODE_I),
        .pin_o(PIN_O),
        .pin_oe_o(PIN_OE_O),
        .pullup_o(PULLUP_O),
        .high_drive_o(HIGH_DRIVE_O),
        .alt_sel_o(ALT_SEL_O),
        .pin_in_o(PIN_IN_O),
        .wake_o(WAKE_O)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [7:0] chk_pin_prev_q;

    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
            chk_pin_prev_q <= '0;
        else
            chk_pin_prev_q <= PIN_I;
    end

    sequence s_ctl_write(logic [7:0] idx);
        WR_EN_I && REG_SEL_I == gpio_cfg_pkg::SEL_CTL && index_q == idx;
    endsequence

    sequence s_ctl_read;
        RD_EN_I && REG_SEL_I == gpio_cfg_pkg::SEL_CTL;
    endsequence

    property p_write_af;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_ctl_write(gpio_cfg_pkg::IDX_AF) |=> cfg.af == $past(WDATA_I);
    endproperty
    a_write_af: assert property (p_write_af)
        else $error("alternate enable write lost");

    property p_write_od;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_ctl_write(gpio_cfg_pkg::IDX_OD) |=> cfg.od == $past(WDATA_I);
    endproperty
    a_write_od: assert property (p_write_od)
        else $error("open drain write lost");

    property p_write_hd;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_ctl_write(gpio_cfg_pkg::IDX_HD) ##1 !WR_EN_I |=> HIGH_DRIVE_O == $past(WDATA_I, 2);
    endproperty
    a_write_hd: assert property (p_write_hd)
        else $error("high drive not reaching pad");

    property p_write_wake;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_ctl_write(gpio_cfg_pkg::IDX_WAKE) |=> cfg.wake == $past(WDATA_I);
    endproperty
    a_write_wake: assert property (p_write_wake)
        else $error("wake source write lost");

    property p_write_pu;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_ctl_write(gpio_cfg_pkg::IDX_PU) ##1 !WR_EN_I |=> PULLUP_O == $past(WDATA_I, 2);
    endproperty
    a_write_pu: assert property (p_write_pu)
        else $error("pull-up not reaching pad");

    property p_write_as1;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_ctl_write(gpio_cfg_pkg::IDX_AS1) |=> cfg.as1 == $past(WDATA_I);
    endproperty
    a_write_as1: assert property (p_write_as1)
        else $error("first set write lost");

    property p_write_as2;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_ctl_write(gpio_cfg_pkg::IDX_AS2) |=> cfg.as2 == $past(WDATA_I);
    endproperty
    a_write_as2: assert property (p_write_as2)
        else $error("second set write lost");

    property p_unmapped_read;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_ctl_read and !is_mapped(index_q) |=> RDATA_O == gpio_cfg_pkg::RST_ZERO;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped index returned data");

    property p_unmapped_write;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        WR_EN_I && REG_SEL_I == gpio_cfg_pkg::SEL_CTL && !is_mapped(index_q)
            |=> $stable(cfg.af) && $stable(cfg.od) && $stable(cfg.dir);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write)
        else $error("unmapped index changed a sub-register");

    property p_readback;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_ctl_write(gpio_cfg_pkg::IDX_PU) ##1 (s_ctl_read and !WR_EN_I)
            |=> RDATA_O == $past(WDATA_I, 2);
    endproperty
    a_readback: assert property (p_readback)
        else $error("read did not return written value");

    property p_od_no_high;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        ##1 (PIN_OE_O & PIN_O & $past(cfg.od)) == 8'h00;
    endproperty
    a_od_no_high: assert property (p_od_no_high)
        else $error("open-drain pin drove high");

    property p_gpio_dir;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        ##1 ((~$past(cfg.af)) & (PIN_OE_O ^ ~($past(cfg.dir)
            | ($past(cfg.od) & $past(OUT_DATA_I))))) == 8'h00;
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("plain io enable does not follow direction");

    property p_wake;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        STOP_MODE_I && ((PIN_I ^ chk_pin_prev_q) & cfg.wake) != 8'h00 |=> WAKE_O;
    endproperty
    a_wake: assert property (p_wake)
        else $error("enabled transition in stop gave no wake");

    property p_no_wake;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        !STOP_MODE_I || ((PIN_I ^ chk_pin_prev_q) & cfg.wake) == 8'h00 |=> !WAKE_O;
    endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("wake without enabled transition in stop");

    property p_alt_sel;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        ##1 ALT_SEL_O[1:0] == {$past(cfg.as2[0]), $past(cfg.as1[0])};
    endproperty
    a_alt_sel: assert property (p_alt_sel)
        else $error("alternate select pairing wrong");

    property p_write_dir;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        s_ctl_write(gpio_cfg_pkg::IDX_DIR) |=> cfg.dir == $past(WDATA_I);
    endproperty
    a_write_dir: assert property (p_write_dir)
        else $error("direction write lost");

    property p_index_read;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        RD_EN_I && REG_SEL_I == gpio_cfg_pkg::SEL_ADDR |=> RDATA_O == $past(index_q);
    endproperty
    a_index_read: assert property (p_index_read)
        else $error("address read lost the index");

endmodule : gpio_port_cfg

// ==== verification/tb_gpio_pin_config_subregs.sv ====
// self-checking testbench for the port configuration sub-registers
`timescale 1ns/1ps
module tb_gpio_pin_config_subregs;
    logic CLOCK_I = 1'b0;
    logic RSTN_I = 1'b0;
    logic REG_SEL_I = 1'b0;
    logic WR_EN_I = 1'b0;
    logic RD_EN_I = 1'b0;
    logic [7:0] WDATA_I = 8'h00;
    logic [7:0] OUT_DATA_I = 8'h00;
    logic [31:0] ALT_OUT_I = 32'h0000_0000;
    logic [31:0] ALT_OE_I = 32'h0000_0000;
    logic [7:0] PIN_I = 8'h00;
    logic STOP_MODE_I = 1'b0;
    logic [7:0] RDATA_O;
    logic [7:0] PIN_O;
    logic [7:0] PIN_OE_O;
    logic [7:0] PULLUP_O;
    logic [7:0] HIGH_DRIVE_O;
    logic [15:0] ALT_SEL_O;
    logic [7:0] PIN_IN_O;
    logic WAKE_O;
    logic [7:0] rdata_small;
    logic [7:0] rdata_plain;
    logic [7:0] cfg [1:8];
    int bad_count = 0;
    int checked = 0;

    always #12.5 CLOCK_I = ~CLOCK_I;

    gpio_port_cfg #(.PORT_ID(gpio_cfg_pkg::PORT_D), .SMALL_PACKAGE(1'b0)) u_dut (
        .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .REG_SEL_I(REG_SEL_I), .WR_EN_I(WR_EN_I),
        .RD_EN_I(RD_EN_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .OUT_DATA_I(OUT_DATA_I),
        .ALT_OUT_I(ALT_OUT_I), .ALT_OE_I(ALT_OE_I), .PIN_I(PIN_I), .STOP_MODE_I(STOP_MODE_I),
        .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O), .PULLUP_O(PULLUP_O), .HIGH_DRIVE_O(HIGH_DRIVE_O),
        .ALT_SEL_O(ALT_SEL_O), .PIN_IN_O(PIN_IN_O), .WAKE_O(WAKE_O)
    );

    // other port builds sharing the bus, checked for reset contents only
    gpio_port_cfg #(.PORT_ID(gpio_cfg_pkg::PORT_A), .SMALL_PACKAGE(1'b1)) u_dut_small (
        .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .REG_SEL_I(REG_SEL_I), .WR_EN_I(WR_EN_I),
        .RD_EN_I(RD_EN_I), .WDATA_I(WDATA_I), .RDATA_O(rdata_small), .OUT_DATA_I(OUT_DATA_I),
        .ALT_OUT_I(ALT_OUT_I), .ALT_OE_I(ALT_OE_I), .PIN_I(PIN_I), .STOP_MODE_I(STOP_MODE_I),
        .PIN_O(), .PIN_OE_O(), .PULLUP_O(), .HIGH_DRIVE_O(), .ALT_SEL_O(), .PIN_IN_O(),
        .WAKE_O()
    );

    gpio_port_cfg #(.PORT_ID(gpio_cfg_pkg::PORT_B), .SMALL_PACKAGE(1'b1)) u_dut_plain (
        .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .REG_SEL_I(REG_SEL_I), .WR_EN_I(WR_EN_I),
        .RD_EN_I(RD_EN_I), .WDATA_I(WDATA_I), .RDATA_O(rdata_plain), .OUT_DATA_I(OUT_DATA_I),
        .ALT_OUT_I(ALT_OUT_I), .ALT_OE_I(ALT_OE_I), .PIN_I(PIN_I), .STOP_MODE_I(STOP_MODE_I),
        .PIN_O(), .PIN_OE_O(), .PULLUP_O(), .HIGH_DRIVE_O(), .ALT_SEL_O(), .PIN_IN_O(),
        .WAKE_O()
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one strobe cycle, driven at the falling edge
    task automatic bus(input logic sel, input logic wr, input logic [7:0] data);
        @(negedge CLOCK_I);
        REG_SEL_I = sel;
        WDATA_I = data;
        WR_EN_I = wr;
        RD_EN_I = ~wr;
        @(negedge CLOCK_I);
        WR_EN_I = 1'b0;
        RD_EN_I = 1'b0;
    endtask : bus

    task automatic rd(input logic sel, input logic [7:0] exp);
        bus(sel, 1'b0, 8'h00);
        @(negedge CLOCK_I);
        chk(RDATA_O, exp);
    endtask : rd

    task automatic wr_sub(input logic [7:0] idx, input logic [7:0] val);
        bus(gpio_cfg_pkg::SEL_ADDR, 1'b1, idx);
        bus(gpio_cfg_pkg::SEL_CTL, 1'b1, val);
        if (idx >= 8'h01 && idx <= 8'h08)
        begin
            cfg[idx[3:0]] = val;
        end
    endtask : wr_sub

    task automatic rd_sub(input logic [7:0] idx, input logic [7:0] exp);
        bus(gpio_cfg_pkg::SEL_ADDR, 1'b1, idx);
        rd(gpio_cfg_pkg::SEL_CTL, exp);
        rd(gpio_cfg_pkg::SEL_ADDR, idx);
    endtask : rd_sub

    task automatic check_all();
        for (int i = 1; i <= 8; i++)
        begin
            rd_sub(8'(i), cfg[i]);
        end
    endtask : check_all

    // expected pad values worked out from the mirror
    task automatic check_pins();
        logic [7:0] d;
        logic [7:0] e;
        logic [15:0] s;
        int f;
        repeat (2) @(negedge CLOCK_I);
        for (int p = 0; p < 8; p++)
        begin
            f = {cfg[8][p], cfg[7][p]};
            d[p] = cfg[2][p] ? ALT_OUT_I[8*f+p] : OUT_DATA_I[p];
            e[p] = cfg[2][p] ? ALT_OE_I[8*f+p] : ~cfg[1][p];
            e[p] = e[p] & ~(cfg[3][p] & d[p]);
            s[2*p] = cfg[7][p];
            s[2*p+1] = cfg[8][p];
        end
        chk(PIN_OE_O, e);
        chk(PIN_O & e, d & e);
        chk(PULLUP_O, cfg[6]);
        chk(HIGH_DRIVE_O, cfg[4]);
        chk(ALT_SEL_O, s);
    endtask : check_pins

    task automatic wake_try(input logic [7:0] pins, input int exp);
        int n;
        n = 0;
        @(negedge CLOCK_I);
        PIN_I = pins;
        repeat (4)
        begin
            @(negedge CLOCK_I);
            if (WAKE_O === 1'b1)
            begin
                n++;
            end
        end
        chk(32'(n), 32'(exp));
        chk(PIN_IN_O, pins);
    endtask : wake_try

    task automatic do_reset();
        @(negedge CLOCK_I);
        RSTN_I = 1'b0;
        for (int i = 1; i <= 8; i++)
        begin
            cfg[i] = 8'h00;
        end
        cfg[1] = 8'hFF;
        cfg[2] = 8'h01;
        repeat (16) @(posedge CLOCK_I);
        @(negedge CLOCK_I);
        RSTN_I = 1'b1;
    endtask : do_reset

    // reset contents of all three port builds
    task automatic check_builds();
        logic [7:0] want [1:8];
        want = '{8'hFF, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04};
        for (int i = 1; i <= 8; i++)
        begin
            bus(gpio_cfg_pkg::SEL_ADDR, 1'b1, 8'(i));
            rd(gpio_cfg_pkg::SEL_CTL, cfg[i]);
            chk(rdata_small, want[i]);
            chk(rdata_plain, (i == 1) ? 8'hFF : 8'h00);
        end
    endtask : check_builds

    // control write followed straight by a control read
    task automatic wr_rd_ctl(input logic [7:0] val);
        @(negedge CLOCK_I);
        REG_SEL_I = gpio_cfg_pkg::SEL_CTL;
        WDATA_I = val;
        WR_EN_I = 1'b1;
        @(negedge CLOCK_I);
        WR_EN_I = 1'b0;
        RD_EN_I = 1'b1;
        @(negedge CLOCK_I);
        RD_EN_I = 1'b0;
        @(negedge CLOCK_I);
        chk(RDATA_O, val);
    endtask : wr_rd_ctl

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge CLOCK_I);
        bad_count++;
        end_of_test();
    end

    initial
    begin
        logic [7:0] vals [1:8];
        logic [7:0] bad_idx [3];
        vals = '{8'h0F, 8'h00, 8'h00, 8'h3C, 8'h81, 8'hA5, 8'hCA, 8'hF0};
        bad_idx = '{8'h00, 8'h09, 8'hFF};
        do_reset();
        check_builds();
        check_all();
        check_pins();
        foreach (bad_idx[k])
        begin
            wr_sub(bad_idx[k], 8'hFF);
            rd_sub(bad_idx[k], 8'h00);
        end
        check_all();
        for (int i = 1; i <= 8; i++)
        begin
            wr_sub(8'(i), vals[i]);
        end
        check_all();
        OUT_DATA_I = 8'h5A;
        check_pins();
        wr_sub(gpio_cfg_pkg::IDX_OD, 8'h33);
        check_pins();
        ALT_OUT_I = 32'hA5C3_3C5A;
        ALT_OE_I = 32'h0FF0_F00F;
        wr_sub(gpio_cfg_pkg::IDX_AF, 8'hFF);
        check_pins();
        wr_sub(gpio_cfg_pkg::IDX_OD, 8'hFF);
        check_pins();
        bus(gpio_cfg_pkg::SEL_ADDR, 1'b1, gpio_cfg_pkg::IDX_PU);
        wr_rd_ctl(8'h3C);
        cfg[6] = 8'h3C;
        check_pins();
        STOP_MODE_I = 1'b1;
        wake_try(8'h02, 0);
        wake_try(8'h82, 1);
        wake_try(8'h02, 1);
        STOP_MODE_I = 1'b0;
        wake_try(8'h83, 0);
        PIN_I = 8'h00;
        do_reset();
        check_builds();
        check_all();
        check_pins();
        end_of_test();
    end
endmodule : tb_gpio_pin_config_subregs
